// >>> rtl/sbi_pkg.sv
// Package of constants for the beamline station safety interlock.
package sbi_pkg;
   // Station states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_SEARCH = 3'h1,
      ST_WARN   = 3'h2,
      ST_SECURE = 3'h3,
      ST_TRIP   = 3'h4
   } sbi_state_t;

   // Clock and timing
   localparam longint unsigned CLK_HZ = 64'd125_000_000;
   localparam longint unsigned BEACON_S = 64'd25;
   localparam longint unsigned BEACON_CYC = BEACON_S * CLK_HZ;
   localparam longint unsigned SHUT_LIMIT_MS = 64'd2;
   localparam longint unsigned SHUT_LIMIT_CYC = SHUT_LIMIT_MS * CLK_HZ / 64'd1000;
   localparam int TMR_W = 34;

   // Default sizes
   localparam int NUM_SHUT = 5;
   localparam int NUM_DOOR = 1;
   localparam int NUM_FLOW = 2;
   localparam int NUM_ESTOP = 2;
   localparam int NUM_BOX = 4;
   localparam int NUM_FE = 3;

   // Monitoring port
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_INPUTS = 4'h4;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// >>> rtl/sbi_link_if.sv
// Interface between station interlock and ring interlock.
`timescale 1ns/1ns
interface sbi_link_if #(parameter int NFE = sbi_pkg::NUM_FE);
   logic stationPermit;
   logic [NFE-1:0] feClosedA;
   logic [NFE-1:0] feClosedB;
   logic [NFE-1:0] feOpenA;
   logic [NFE-1:0] feOpenB;

   modport station (output stationPermit, input feClosedA, feClosedB, feOpenA, feOpenB);
   modport ring (input stationPermit, output feClosedA, feClosedB, feOpenA, feOpenB);
endinterface

// >>> rtl/sbi_chain.sv
// One redundant evaluation chain with its own input synchronisers.
`timescale 1ns/1ns
module sbi_chain #(
   parameter int NSH = sbi_pkg::NUM_SHUT,
   parameter int NDR = sbi_pkg::NUM_DOOR,
   parameter int NFL = sbi_pkg::NUM_FLOW,
   parameter int NES = sbi_pkg::NUM_ESTOP
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Field switches of this chain
   input wire logic [NSH-1:0] shutClosedRaw,
   input wire logic [NSH-1:0] shutOpenRaw,
   input wire logic [NDR-1:0] doorClosedRaw,
   input wire logic [NFL-1:0] flowOkRaw,
   input wire logic [NES-1:0] estopRaw,
   // Evaluation
   output logic healthy,
   output logic doorsClosed,
   output logic shutAllClosed,
   output logic estopHit
);
   localparam int W = 2 * NSH + NDR + NFL + NES;
   logic [W-1:0] raw, s1_q, s2_q, s3_q, st_q, st_d;
   logic [NSH-1:0] shC, shO;
   logic [NDR-1:0] drC;
   logic [NFL-1:0] flOk;
   logic [NES-1:0] es;

   assign raw = {shutClosedRaw, shutOpenRaw, doorClosedRaw, flowOkRaw, estopRaw};

   // A change counts only once stages two and three agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         st_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : st_q[i];
      end
   end

   // Reset to the unsafe-looking value so nothing is trusted early
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         st_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= st_d;
      end
   end

   assign {shC, shO, drC, flOk, es} = st_q;

   // Closed and open both seen means a broken switch: unsafe
   assign healthy = (&flOk) & ~(|es) & ~(|(shC & shO));
   assign doorsClosed = &drC;
   assign shutAllClosed = &(shC & ~shO);
   assign estopHit = |es;
endmodule // sbi_chain

// >>> rtl/sbi_station.sv
// Station personnel interlock: search sequence, two chains, permit, read-only monitor.
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module sbi_station #(
   parameter int NSH = sbi_pkg::NUM_SHUT,
   parameter int NDR = sbi_pkg::NUM_DOOR,
   parameter int NFL = sbi_pkg::NUM_FLOW,
   parameter int NES = sbi_pkg::NUM_ESTOP,
   parameter int NBX = sbi_pkg::NUM_BOX,
   parameter longint unsigned BEACON_CYC = sbi_pkg::BEACON_CYC,
   parameter longint unsigned SHUT_LIMIT_CYC = sbi_pkg::SHUT_LIMIT_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Link to ring interlock
   sbi_link_if.station link,
   // Chain A field switches
   input wire logic [NSH-1:0] shutClosedA,
   input wire logic [NSH-1:0] shutOpenA,
   input wire logic [NDR-1:0] doorClosedA,
   input wire logic [NFL-1:0] flowOkA,
   input wire logic [NES-1:0] estopA,
   // Chain B field switches
   input wire logic [NSH-1:0] shutClosedB,
   input wire logic [NSH-1:0] shutOpenB,
   input wire logic [NDR-1:0] doorClosedB,
   input wire logic [NFL-1:0] flowOkB,
   input wire logic [NES-1:0] estopB,
   // Station buttons
   input wire logic searchStart,
   input wire logic [NBX-1:0] searchBox,
   input wire logic egressPress,
   // Equipment protection controller
   input wire logic eqFault,
   output logic shutterPermit,
   output logic shutterCloseReq,
   // Station outputs
   output logic doorLock,
   output logic beacon,
   output logic hazardTrip,
   // Avalon-MM monitoring slave
   input wire logic [sbi_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam int TW = sbi_pkg::TMR_W;
   localparam logic [TW-1:0] BEACON_END = TW'(BEACON_CYC);
   localparam logic [TW-1:0] SHUT_END = TW'(SHUT_LIMIT_CYC);
   localparam int BW = NBX + 3;

   logic okA, okB, drA, drB, shA, shB, esA, esB;
   logic [BW-1:0] b1_q, b2_q, b3_q, bt_q, bt_d;
   logic start, egress, eqBad;
   logic [NBX-1:0] box;
   sbi_pkg::sbi_state_t state_q, state_d;
   logic [NBX-1:0] acked_q, acked_d;
   logic [TW-1:0] beacTmr_q, beacTmr_d, shutTmr_q, shutTmr_d;
   logic permit_q, permit_d, lock_q, lock_d, beacon_q, beacon_d;
   logic closeReq_q, closeReq_d, shutLate_q, shutLate_d;
   logic rsp_q, rsp_d;
   logic [31:0] rdata_q, rdata_d;
   logic bothOk, bothDoor, breach;

   // Two independent chains
   sbi_chain #(.NSH(NSH), .NDR(NDR), .NFL(NFL), .NES(NES)) chainA (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .shutClosedRaw(shutClosedA),
      .shutOpenRaw(shutOpenA),
      .doorClosedRaw(doorClosedA),
      .flowOkRaw(flowOkA),
      .estopRaw(estopA),
      .healthy(okA),
      .doorsClosed(drA),
      .shutAllClosed(shA),
      .estopHit(esA)
   );
   sbi_chain #(.NSH(NSH), .NDR(NDR), .NFL(NFL), .NES(NES)) chainB (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .shutClosedRaw(shutClosedB),
      .shutOpenRaw(shutOpenB),
      .doorClosedRaw(doorClosedB),
      .flowOkRaw(flowOkB),
      .estopRaw(estopB),
      .healthy(okB),
      .doorsClosed(drB),
      .shutAllClosed(shB),
      .estopHit(esB)
   );

   // Button and eqFault synchronisers, same agree-on-two-stages scheme as the chains
   always_comb begin
      for (int i = 0; i < BW; i++) begin
         bt_d[i] = (b2_q[i] == b3_q[i]) ? b3_q[i] : bt_q[i];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         b1_q <= '0;
         b2_q <= '0;
         b3_q <= '0;
         bt_q <= '0;
      end else begin
         b1_q <= {searchStart, searchBox, egressPress, eqFault};
         b2_q <= b1_q;
         b3_q <= b2_q;
         bt_q <= bt_d;
      end
   end

   assign {start, box, egress, eqBad} = bt_q;

   // Disagreement between chains counts as a breach
   assign bothOk = okA & okB;
   assign bothDoor = drA & drB;
   assign breach = ~bothOk | ~bothDoor | esA | esB | egress | eqBad | shutLate_q;

   // Search sequence and permit
   always_comb begin
      state_d = state_q;
      acked_d = acked_q;
      beacTmr_d = beacTmr_q;
      unique case (state_q)
         sbi_pkg::ST_IDLE, sbi_pkg::ST_TRIP: begin
            if (start) begin
               state_d = sbi_pkg::ST_SEARCH;
               acked_d = '0;
            end else if (eqBad | shutLate_q) begin // Trips with no search running
               state_d = sbi_pkg::ST_TRIP;
            end
         end
         sbi_pkg::ST_SEARCH: begin
            acked_d = acked_q | box;
            if (esA | esB | eqBad | shutLate_q) begin
               state_d = sbi_pkg::ST_TRIP;
            end else if ((&acked_q) & bothDoor & ~egress) begin
               state_d = sbi_pkg::ST_WARN;
               beacTmr_d = '0;
            end
         end
         sbi_pkg::ST_WARN: begin
            beacTmr_d = beacTmr_q + TW'(1);
            if (breach) begin
               state_d = sbi_pkg::ST_TRIP;
            end else if (beacTmr_q >= BEACON_END - TW'(1)) begin
               state_d = sbi_pkg::ST_SECURE;
            end
         end
         sbi_pkg::ST_SECURE: begin
            if (breach) begin
               state_d = sbi_pkg::ST_TRIP;
            end
         end
         default: state_d = sbi_pkg::ST_TRIP; // Illegal code fails safe
      endcase
   end

   // Station outputs follow the next state so a trip shows at the same edge as the state change
   always_comb begin
      permit_d = (state_d == sbi_pkg::ST_SECURE) & ~breach;
      lock_d = ((state_d == sbi_pkg::ST_WARN) | (state_d == sbi_pkg::ST_SECURE)) & ~egress;
      beacon_d = (state_d == sbi_pkg::ST_SEARCH) | (state_d == sbi_pkg::ST_WARN);
      closeReq_d = ~permit_d;
      shutLate_d = shutLate_q;
      shutTmr_d = '0;
      if (start & (state_q != sbi_pkg::ST_SECURE)) begin
         shutLate_d = 1'b0; // Cleared only by a search start while the state is not ST_SECURE
      end
      // Set wins over clear: a shutter still late at search start keeps the flag
      if (closeReq_q & ~(shA & shB)) begin
         shutTmr_d = shutTmr_q + TW'(1);
         if (shutTmr_q >= SHUT_END - TW'(1)) begin
            shutLate_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= sbi_pkg::ST_IDLE;
         acked_q <= '0;
         beacTmr_q <= '0;
         shutTmr_q <= '0;
         permit_q <= 1'b0;
         lock_q <= 1'b0;
         beacon_q <= 1'b0;
         closeReq_q <= 1'b1;
         shutLate_q <= 1'b0;
      end else begin
         state_q <= state_d;
         acked_q <= acked_d;
         beacTmr_q <= beacTmr_d;
         shutTmr_q <= shutTmr_d;
         permit_q <= permit_d;
         lock_q <= lock_d;
         beacon_q <= beacon_d;
         closeReq_q <= closeReq_d;
         shutLate_q <= shutLate_d;
      end
   end

   assign link.stationPermit = permit_q;
   assign shutterPermit = permit_q;
   assign shutterCloseReq = closeReq_q;
   assign doorLock = lock_q;
   assign beacon = beacon_q;
   assign hazardTrip = (state_q == sbi_pkg::ST_TRIP);

   // Monitoring slave: one wait cycle, writes accepted and discarded
   always_comb begin
      rsp_d = (avs_read | avs_write) & ~rsp_q;
      rdata_d = rdata_q;
      if (avs_read & ~rsp_q) begin
         unique case (avs_address)
            sbi_pkg::OFS_STATUS: rdata_d = {22'h0, shutLate_q, hazardTrip, closeReq_q,
                                            beacon_q, lock_q, permit_q, 1'b0, state_q};
            sbi_pkg::OFS_INPUTS: rdata_d = {20'h0, link.feClosedA[0], link.feClosedB[0],
                                            eqBad, egress, esA, esB, shA, shB, drA, drB,
                                            okA, okB};
            default: rdata_d = sbi_pkg::RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         rsp_q <= rsp_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~rsp_q;
   assign avs_readdata = rdata_q;
endmodule // sbi_station

// >>> rtl/sbi_ring.sv
// Ring personnel interlock end: station permit, bypass key, front-end shutter fan-out.
`timescale 1ns/1ns
module sbi_ring #(
   parameter int NFE = sbi_pkg::NUM_FE
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Link to station interlock
   sbi_link_if.ring link,
   // Front-end shutter switches
   input wire logic [NFE-1:0] feClosedA,
   input wire logic [NFE-1:0] feClosedB,
   input wire logic [NFE-1:0] feOpenA,
   input wire logic [NFE-1:0] feOpenB,
   // Bypass key: high while station interlock is available
   input wire logic stationAvail,
   // Hazard sources
   output logic dipoleOn,
   output logic rfOn
);
   localparam int W = 4 * NFE + 1;
   logic [W-1:0] s1_q, s2_q, s3_q, st_q, st_d;
   logic [NFE-1:0] cA, cB, oA, oB;
   logic avail, ringOk, on_q, on_d;

   // Agree-on-two-stages synchroniser
   always_comb begin
      for (int i = 0; i < W; i++) begin
         st_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : st_q[i];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         st_q <= '0;
      end else begin
         s1_q <= {feClosedA, feClosedB, feOpenA, feOpenB, stationAvail};
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= st_d;
      end
   end

   assign {cA, cB, oA, oB, avail} = st_q;
   assign link.feClosedA = cA;
   assign link.feClosedB = cB;
   assign link.feOpenA = oA;
   assign link.feOpenB = oB;

   // Available: follow the station permit; bypassed: all front-end shutters closed
   always_comb begin
      if (avail) begin
         ringOk = link.stationPermit;
      end else begin
         ringOk = &(cA & cB & ~oA & ~oB);
      end
      on_d = ringOk;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         on_q <= 1'b0;
      end else begin
         on_q <= on_d;
      end
   end

   assign dipoleOn = on_q;
   assign rfOn = on_q;
endmodule // sbi_ring

// >>> verification/sbi_link_properties.sv
// Checker of the station-ring link and the outputs of both ends.
`timescale 1ns/1ns
module sbi_link_properties #(parameter int NFE = sbi_pkg::NUM_FE) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Link and end outputs
   input wire logic stationPermit,
   input wire logic [NFE-1:0] feOpenA,
   input wire logic shutterPermit,
   input wire logic shutterCloseReq,
   input wire logic doorLock,
   input wire logic beacon,
   input wire logic hazardTrip,
   input wire logic stationAvail,
   input wire logic dipoleOn,
   input wire logic rfOn,
   input wire logic avs_read,
   input wire logic avs_waitrequest
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // A monitor read waits one cycle, then completes
   sequence waitOne;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   // Trip seen on two samples in a row
   sequence tripHeld;
      hazardTrip ##1 hazardTrip;
   endsequence
   AST_WAIT_ONE: assert property ($rose(avs_read) |-> waitOne)
      else $error("monitor wait not one cycle");
   AST_PERMIT_COPY: assert property (shutterPermit == stationPermit)
      else $error("shutter permit differs from link permit");
   AST_CLOSE_REQ: assert property (shutterCloseReq == !shutterPermit)
      else $error("close request not opposite of permit");
   AST_PERMIT_LOCK: assert property (stationPermit |-> doorLock)
      else $error("permit with door unlocked");
   AST_PERMIT_QUIET: assert property (stationPermit |-> !beacon)
      else $error("beacon still on with permit");
   AST_TRIP_DROP: assert property (tripHeld |-> !stationPermit)
      else $error("permit kept during trip");
   AST_RING_AGREE: assert property (dipoleOn == rfOn)
      else $error("dipole and RF disagree");
   AST_RING_DROP: assert property ((stationAvail && !stationPermit)[*8] |-> !dipoleOn)
      else $error("ring hazard kept without permit");
   AST_RING_BYPASS: assert property ((!stationAvail && feOpenA != 0)[*8] |-> !rfOn)
      else $error("bypassed ring kept hazard with shutter open");
   AST_RING_AVAIL: assert property ((stationAvail && stationPermit)[*8] |-> dipoleOn)
      else $error("ring refused hazard with permit");
endmodule // sbi_link_properties

// >>> verification/beamline_station_safety_interlock_test.sv
// Bench joining the station and ring ends over the link.
`timescale 1ns/1ns
module beamline_station_safety_interlock_test;
   // Chain field vector: estop, flow, door, open, closed
   localparam logic [14:0] NOM = 15'h1C1F;
   localparam logic [14:0] DOOR_OPEN = 15'h181F;
   localparam logic [14:0] MASK_A [7] = '{15'h2000, 15'h0, 15'h0400, 15'h0, 15'h0200, 15'h0, 15'h0};
   localparam logic [14:0] MASK_B [7] = '{15'h0, 15'h0800, 15'h0, 15'h0020, 15'h0, 15'h0, 15'h0};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [14:0] fieldA = NOM;
   logic [14:0] fieldB = NOM;
   logic start = 1'b0;
   logic [3:0] box = 4'h0;
   logic egress = 1'b0;
   logic eqFault = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [2:0] feClA = 3'h7;
   logic [2:0] feClB = 3'h7;
   logic [2:0] feOpA = 3'h0;
   logic [2:0] feOpB = 3'h0;
   logic avail = 1'b1;
   logic shutPermit, closeReq, doorLock, beacon, hazardTrip, dipoleOn, rfOn, wreq;
   logic [31:0] rdata;
   logic [31:0] rd;
   int err_total = 0;
   int total_checks = 0;
   int n;

   sbi_link_if sbi_link_if_i ();
   sbi_station #(.BEACON_CYC(20), .SHUT_LIMIT_CYC(10)) sbi_station_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .link(sbi_link_if_i.station),
      .shutClosedA(fieldA[4:0]), .shutOpenA(fieldA[9:5]), .doorClosedA(fieldA[10]),
      .flowOkA(fieldA[12:11]), .estopA(fieldA[14:13]),
      .shutClosedB(fieldB[4:0]), .shutOpenB(fieldB[9:5]), .doorClosedB(fieldB[10]),
      .flowOkB(fieldB[12:11]), .estopB(fieldB[14:13]),
      .searchStart(start), .searchBox(box), .egressPress(egress), .eqFault(eqFault),
      .shutterPermit(shutPermit), .shutterCloseReq(closeReq), .doorLock(doorLock),
      .beacon(beacon), .hazardTrip(hazardTrip), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(rdata), .avs_waitrequest(wreq));
   sbi_ring sbi_ring_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .link(sbi_link_if_i.ring), .feClosedA(feClA),
      .feClosedB(feClB), .feOpenA(feOpA), .feOpenB(feOpB), .stationAvail(avail),
      .dipoleOn(dipoleOn), .rfOn(rfOn));
   sbi_link_properties sbi_link_properties_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .stationPermit(sbi_link_if_i.stationPermit),
      .feOpenA(sbi_link_if_i.feOpenA), .shutterPermit(shutPermit),
      .shutterCloseReq(closeReq), .doorLock(doorLock), .beacon(beacon),
      .hazardTrip(hazardTrip), .stationAvail(avail), .dipoleOn(dipoleOn), .rfOn(rfOn),
      .avs_read(avs_read), .avs_waitrequest(wreq));

   // 125 MHz clock
   always #4 sys_clk = ~sys_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   // Bounded wait on one output; running out ends the run as a failure
   task automatic waitFor(input int k, input logic v);
      n = 0;
      while ((k == 0 ? beacon : k == 1 ? doorLock : k == 2 ? shutPermit :
              k == 3 ? hazardTrip : dipoleOn) !== v) begin
         @(posedge sys_clk);
         #1;
         n++;
         if (n > 200) begin
            err_total++;
            summarize();
         end
      end
   endtask
   // Monitor access; request held until the edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int i;
      i = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= wd;
      // Waitrequest and read data are judged at the rising edge only
      do begin
         @(posedge sys_clk);
         i++;
         if (i > 50) begin
            err_total++;
            summarize();
         end
      end while (wreq !== 1'b0);
      rd = rdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Full search; probe adds early door close and monitor accesses
   task automatic secure(input bit probe);
      @(posedge sys_clk);
      fieldA <= DOOR_OPEN;
      fieldB <= DOOR_OPEN;
      egress <= 1'b0;
      eqFault <= 1'b0;
      start <= 1'b1;
      box <= 4'h0;
      cyc(3);
      start <= 1'b0;
      waitFor(0, 1'b1);
      check(n <= 8, 1'b1);
      cyc(1);
      box <= 4'h7;
      cyc(2);
      box <= 4'h0;
      fieldA <= probe ? NOM : DOOR_OPEN;
      fieldB <= probe ? NOM : DOOR_OPEN;
      cyc(12);
      check(doorLock, 1'b0);
      box <= 4'h8;
      fieldA <= DOOR_OPEN;
      fieldB <= DOOR_OPEN;
      cyc(3);
      fieldA <= NOM;
      fieldB <= NOM;
      waitFor(1, 1'b1);
      check(beacon, 1'b1);
      waitFor(2, 1'b1);
      check(n >= 19 && n <= 22, 1'b1);
      check(beacon, 1'b0);
      check(closeReq, 1'b0);
      waitFor(4, 1'b1);
      if (probe) begin
         bus(1'b0, 4'h0, 32'h0);
         check(rd, 32'h0000_0033);
         bus(1'b1, 4'h0, 32'hFFFF_FFFF);
         bus(1'b0, 4'h0, 32'h0);
         check(rd, 32'h0000_0033);
         bus(1'b0, 4'h8, 32'h0);
         check(rd, 32'h0000_0000);
      end
   endtask

   // Main sequence
   initial begin
      cyc(20);
      rst_n <= 1'b1;
      cyc(2);
      #1;
      check({shutPermit, closeReq, doorLock, beacon, hazardTrip, dipoleOn}, 6'h10);
      // Shutter stuck in transit while closure is requested
      cyc(1);
      fieldA <= NOM ^ 15'h0010;
      waitFor(3, 1'b1);
      check(n >= 10 && n <= 20, 1'b1);
      bus(1'b0, 4'h0, 32'h0);
      check(rd, 32'h0000_0384);
      // Each breach kind trips and holds until a new search
      for (int k = 0; k < 7; k++) begin
         secure(k == 0);
         @(posedge sys_clk);
         fieldA <= NOM ^ MASK_A[k];
         fieldB <= NOM ^ MASK_B[k];
         eqFault <= (k == 5);
         egress <= (k == 6);
         waitFor(3, 1'b1);
         check(n <= 8, 1'b1);
         check(shutPermit, 1'b0);
         check(closeReq, 1'b1);
         waitFor(4, 1'b0);
         if (k == 6) begin
            bus(1'b0, 4'h0, 32'h0);
            check(rd, 32'h0000_0184);
         end
         @(posedge sys_clk);
         fieldA <= NOM;
         fieldB <= NOM;
         eqFault <= 1'b0;
         egress <= 1'b0;
         cyc(12);
         check({hazardTrip, shutPermit}, 2'h2);
      end
      // Bypassed station: ring follows front-end shutters
      avail <= 1'b0;
      waitFor(4, 1'b1);
      check(sbi_link_if_i.feClosedA, 3'h7);
      @(posedge sys_clk);
      feClB <= 3'h5;
      feOpA <= 3'h2;
      waitFor(4, 1'b0);
      @(posedge sys_clk);
      avail <= 1'b1;
      secure(1'b0);
      check(dipoleOn, 1'b1);
      summarize();
   end
endmodule // beamline_station_safety_interlock_test
